// file: fwpc_pkg.sv
/*
  Constants and types of the flash command controller.
  Assumes a 40 MHz system clock and SPI mode 0 or 3 on the link.
*/
package fwpc_pkg;
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] DEEP_SLEEP_CMD = 8'hB9;
  localparam logic [7:0] RELEASE_ID_CMD = 8'hAB;
  localparam logic [7:0] LONG_ID_CMD = 8'h9F;
  localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
  localparam logic [7:0] SECTOR_ERASE_CMD = 8'h20;
  localparam logic [7:0] SECTOR_ERASE_ALT_CMD = 8'hD7;
  localparam logic [7:0] BLOCK_ERASE_CMD = 8'hD8;
  localparam logic [7:0] CHIP_ERASE_CMD = 8'h60;
  localparam logic [7:0] CHIP_ERASE_ALT_CMD = 8'hC7;
  // Status byte layout
  localparam int SR_BUSY = 0;
  localparam int SR_WRITE_ENABLE = 1;
  localparam int SR_PROTECT_LEVEL_BIT0 = 2;
  localparam int SR_PROTECT_FROM_BOTTOM = 5;
  localparam int SR_STATUS_LOCK = 7;
  localparam logic [2:0] RST_PROTECT_LEVEL = 3'h0;
  localparam logic RST_PROTECT_FROM_BOTTOM = 1'h0;
  localparam logic RST_STATUS_LOCK = 1'h0;
  localparam int BIT_CNT_W = 12;
  localparam int PROG_BYTES_W = BIT_CNT_W - 3;
  localparam logic [BIT_CNT_W-1:0] BITS_CMD = 12'h008;
  localparam logic [BIT_CNT_W-1:0] BITS_STATUS_WR = 12'h010;
  localparam logic [BIT_CNT_W-1:0] BITS_STATUS_WR_REJECT = 12'h020;
  localparam logic [BIT_CNT_W-1:0] BITS_ADDR_END = 12'h020;
  localparam logic [BIT_CNT_W-1:0] BITS_PROG_MIN = 12'h028;
  localparam int TIMER_W = 16;
  localparam int PWR_W = 16;
  localparam int CLK_MHZ = 40;
  localparam int STATUS_WRITE_TIME_NS = 2000;
  localparam int SLEEP_ENTRY_TIME_NS = 3000;
  localparam int WAKE_RECOVERY_TIME_NS = 3000;
  localparam int POWERUP_READ_DELAY_US = 500;
  localparam int STATUS_WRITE_CYCLES =
    (STATUS_WRITE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SLEEP_ENTRY_CYCLES =
    (SLEEP_ENTRY_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_RECOVERY_CYCLES =
    (WAKE_RECOVERY_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int POWERUP_READ_CYCLES = POWERUP_READ_DELAY_US * CLK_MHZ;
  typedef enum logic [2:0] {
    ST_IDLE, ST_STATUS_WR, ST_ARRAY_BUSY, ST_SLEEP_ENTRY, ST_SLEEP, ST_WAKE
  } fwpc_state_t;
endpackage : fwpc_pkg

// file: fwpc_link.sv
/*
  Serial side of the flash command controller, clocked by SCK.
  Assumes SPI mode 0 or 3: SI sampled on the rise, SO changed on the
  fall. Frame fields hold after CE_N rises for the system side to read.
*/
`timescale 1ns/100ps
module fwpc_link
  import fwpc_pkg::*;
#(
  parameter logic [7:0] ID_DEVICE = 8'hA5,
  parameter logic [7:0] ID_LONG_B0 = 8'h5A,
  parameter logic [7:0] ID_LONG_B1 = 8'h3C,
  parameter logic [7:0] ID_LONG_B2 = 8'h0F,
  parameter logic [7:0] ID_LONG_B3 = 8'hC3
) (
  input wire logic sck,
  input wire logic ce_n,
  input wire logic rst_n,
  input wire logic si,
  input wire logic [7:0] status_byte,
  input wire logic asleep,
  output logic [7:0] opcode,
  output logic [7:0] data_byte,
  output logic [BIT_CNT_W-1:0] bit_count,
  output logic so,
  output logic so_oe
);
  typedef struct packed {
    logic [7:0] shift;
    logic [7:0] opcode;
    logic [7:0] data;
    logic [BIT_CNT_W-1:0] cnt;
    logic [7:0] stat_s1;
    logic [7:0] stat_s2;
    logic sleep_s1;
    logic sleep_s2;
  } fwpc_link_t;
  typedef struct packed {
    logic drive;
    logic so;
    logic [7:0] cur;
  } fwpc_out_t;

  fwpc_link_t link_reg, link_next;
  fwpc_out_t out_reg, out_next;
  logic first_reg;
  logic [BIT_CNT_W-1:0] start;
  logic [BIT_CNT_W-1:0] offset;
  logic enable;
  logic [7:0] pick;

  // Marks that no SCK rise has yet been seen in the current frame
  always_ff @(posedge sck or posedge ce_n) begin
    if (ce_n) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  always_comb begin
    link_next = link_reg;
    link_next.shift = {link_reg.shift[6:0], si};
    if (first_reg) begin
      link_next.cnt = 12'h001;
    end else if (link_reg.cnt != 12'hFFF) begin
      link_next.cnt = link_reg.cnt + 12'h001;
    end
    if (link_next.cnt == BITS_CMD) begin
      link_next.opcode = link_next.shift;
    end
    if (link_next.cnt == BITS_STATUS_WR) begin
      link_next.data = link_next.shift;
    end
    link_next.stat_s1 = status_byte;
    link_next.stat_s2 = link_reg.stat_s1;
    link_next.sleep_s1 = asleep;
    link_next.sleep_s2 = link_reg.sleep_s1;
  end

  // Output stream; a long frame saturates the count and freezes SO
  always_comb begin
    start = BITS_CMD;
    enable = 1'b0;
    pick = ID_DEVICE;
    offset = link_reg.cnt - start;
    case (link_reg.opcode)
      STATUS_READ_CMD: begin
        enable = !link_reg.sleep_s2;
        pick = link_reg.stat_s2;
      end
      LONG_ID_CMD: begin
        enable = !link_reg.sleep_s2;
        case (offset[4:3])
          2'h0: pick = ID_LONG_B0;
          2'h1: pick = ID_LONG_B1;
          2'h2: pick = ID_LONG_B2;
          default: pick = ID_LONG_B3;
        endcase
      end
      RELEASE_ID_CMD: begin
        start = BITS_ADDR_END;
        offset = link_reg.cnt - start;
        enable = 1'b1;
      end
      default: enable = 1'b0;
    endcase
    out_next = out_reg;
    out_next.drive = enable && !first_reg && link_reg.cnt >= start;
    if (offset[2:0] == 3'h0) begin
      out_next.cur = pick;
      out_next.so = pick[7];
    end else begin
      out_next.so = out_reg.cur[3'h7 - offset[2:0]];
    end
  end

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  always_ff @(negedge sck or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= '0;
    end else begin
      out_reg <= out_next;
    end
  end

  assign opcode = link_reg.opcode;
  assign data_byte = link_reg.data;
  assign bit_count = link_reg.cnt;
  assign so = out_reg.so;
  assign so_oe = out_reg.drive & ~ce_n;
endmodule : fwpc_link

// file: fwpc_ctrl.sv
/*
  Top of the flash command controller: write-enable latch, status
  write with lock-down, deep sleep entry and release, power-up delay.
  Assumes SCK runs only while CE_N is low, and that the array datapath
  answers each ARRAY_REQ with one ARRAY_DONE pulse on MCLK.
*/
`timescale 1ns/100ps
module fwpc_ctrl
  import fwpc_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_READ_CYCLES,
  parameter logic [7:0] ID_DEVICE = 8'hA5, // Arbitrary value
  parameter logic [7:0] ID_LONG_B0 = 8'h5A, // Arbitrary value
  parameter logic [7:0] ID_LONG_B1 = 8'h3C, // Arbitrary value
  parameter logic [7:0] ID_LONG_B2 = 8'h0F, // Arbitrary value
  parameter logic [7:0] ID_LONG_B3 = 8'hC3 // Arbitrary value
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SCK,
  input wire logic CE_N,
  input wire logic SI,
  input wire logic WP_N,
  input wire logic ARRAY_DONE,
  output logic SO,
  output logic SO_OE,
  output logic ARRAY_REQ,
  output logic [7:0] ARRAY_OP,
  output logic [PROG_BYTES_W-1:0] ARRAY_BYTES,
  output logic BUSY,
  output logic WRITE_ENABLED,
  output logic [2:0] PROTECT_LEVEL,
  output logic PROTECT_FROM_BOTTOM,
  output logic STATUS_LOCK,
  output logic ASLEEP,
  output logic PWR_READY
);
  typedef struct packed {
    fwpc_state_t state;
    logic write_enable;
    logic [2:0] protect_level;
    logic protect_from_bottom;
    logic status_lock;
    logic [TIMER_W-1:0] timer;
    logic [PWR_W-1:0] pwr_cnt;
    logic pwr_ready;
    logic [2:0] ce_sync;
    logic [1:0] wp_sync;
    logic array_req;
    logic [7:0] array_op;
    logic [PROG_BYTES_W-1:0] array_bytes;
  } fwpc_ctrl_t;

  localparam logic [TIMER_W-1:0] SW_LOAD =
    TIMER_W'(STATUS_WRITE_CYCLES - 1);
  localparam logic [TIMER_W-1:0] SE_LOAD =
    TIMER_W'(SLEEP_ENTRY_CYCLES - 1);
  localparam logic [TIMER_W-1:0] WR_LOAD =
    TIMER_W'(WAKE_RECOVERY_CYCLES - 1);
  localparam logic [PWR_W-1:0] PWR_LAST = PWR_W'(POWERUP_CYCLES - 1);

  fwpc_ctrl_t ctrl_reg, ctrl_next;
  logic [7:0] op;
  logic [7:0] data;
  logic [BIT_CNT_W-1:0] bits;
  logic [BIT_CNT_W-1:0] prog_span;
  logic [7:0] status_byte;
  logic frame_end;
  logic cmd_seen;
  logic aligned;
  logic wp_s;
  logic locked;
  logic in_status_wr;

  // Erase commands and the frame length each one needs
  function automatic logic is_erase(input logic [7:0] code);
    is_erase = code == SECTOR_ERASE_CMD || code == SECTOR_ERASE_ALT_CMD ||
      code == BLOCK_ERASE_CMD || code == CHIP_ERASE_CMD ||
      code == CHIP_ERASE_ALT_CMD;
  endfunction : is_erase

  function automatic logic [BIT_CNT_W-1:0] erase_bits(
    input logic [7:0] code
  );
    if (code == CHIP_ERASE_CMD || code == CHIP_ERASE_ALT_CMD) begin
      erase_bits = BITS_CMD;
    end else begin
      erase_bits = BITS_ADDR_END;
    end
  endfunction : erase_bits

  fwpc_link #(
    .ID_DEVICE(ID_DEVICE),
    .ID_LONG_B0(ID_LONG_B0),
    .ID_LONG_B1(ID_LONG_B1),
    .ID_LONG_B2(ID_LONG_B2),
    .ID_LONG_B3(ID_LONG_B3)
  ) u_link (
    .sck(SCK),
    .ce_n(CE_N),
    .rst_n(RST_N),
    .si(SI),
    .status_byte(status_byte),
    .asleep(ASLEEP),
    .opcode(op),
    .data_byte(data),
    .bit_count(bits),
    .so(SO),
    .so_oe(SO_OE)
  );

  // Frame fields are quiet once CE_N is high, so they are read here
  // without a further crossing, two MCLK edges after the rise.
  assign frame_end = ctrl_reg.ce_sync[1] & ~ctrl_reg.ce_sync[2];
  assign cmd_seen = bits >= BITS_CMD;
  assign aligned = bits[2:0] == 3'h0;
  assign wp_s = ctrl_reg.wp_sync[1];
  // WP_N sample taken at the same MCLK edge as the first high CE_N sample decides the lock
  assign locked = !wp_s && ctrl_reg.status_lock;
  assign prog_span = bits - BITS_ADDR_END;
  assign in_status_wr = ctrl_reg.state == ST_STATUS_WR;

  always_comb begin
    ctrl_next = ctrl_reg;
    ctrl_next.ce_sync = {ctrl_reg.ce_sync[1:0], CE_N};
    ctrl_next.wp_sync = {ctrl_reg.wp_sync[0], WP_N};
    ctrl_next.array_req = 1'b0;
    if (!ctrl_reg.pwr_ready) begin
      ctrl_next.pwr_cnt = ctrl_reg.pwr_cnt + 16'h0001;
      ctrl_next.pwr_ready = ctrl_reg.pwr_cnt == PWR_LAST;
    end
    if (ctrl_reg.timer != '0) begin
      ctrl_next.timer = ctrl_reg.timer - 16'h0001;
    end
    case (ctrl_reg.state)
      ST_IDLE: begin
        if (frame_end && cmd_seen) begin
          case (op)
            WRITE_ENABLE_CMD: begin
              if (aligned) begin
                ctrl_next.write_enable = 1'b1;
              end
            end
            WRITE_DISABLE_CMD: begin
              if (aligned) begin
                ctrl_next.write_enable = 1'b0;
              end
            end
            STATUS_WRITE_CMD: begin
              if (ctrl_reg.write_enable && aligned &&
                  bits >= BITS_STATUS_WR &&
                  bits < BITS_STATUS_WR_REJECT &&
                  !locked) begin
                ctrl_next.protect_level =
                  data[SR_PROTECT_LEVEL_BIT0 +: 3];
                ctrl_next.protect_from_bottom =
                  data[SR_PROTECT_FROM_BOTTOM];
                if (wp_s) begin
                  ctrl_next.status_lock = data[SR_STATUS_LOCK];
                end else begin
                  // Pin low and unlocked: lock may only be set
                  ctrl_next.status_lock =
                    ctrl_reg.status_lock | data[SR_STATUS_LOCK];
                end
                ctrl_next.write_enable = 1'b0;
                ctrl_next.timer = SW_LOAD;
                ctrl_next.state = ST_STATUS_WR;
              end
            end
            PAGE_PROGRAM_CMD: begin
              // Partial trailing byte is dropped by the shift
              if (ctrl_reg.write_enable && bits >= BITS_PROG_MIN) begin
                ctrl_next.array_req = 1'b1;
                ctrl_next.array_op = op;
                ctrl_next.array_bytes =
                  prog_span[BIT_CNT_W-1:3];
                ctrl_next.state = ST_ARRAY_BUSY;
              end
            end
            DEEP_SLEEP_CMD: begin
              if (aligned) begin
                ctrl_next.timer = SE_LOAD;
                ctrl_next.state = ST_SLEEP_ENTRY;
              end
            end
            default: begin
              if (is_erase(op) && ctrl_reg.write_enable && aligned &&
                  bits >= erase_bits(op)) begin
                ctrl_next.array_req = 1'b1;
                ctrl_next.array_op = op;
                ctrl_next.array_bytes = '0;
                ctrl_next.state = ST_ARRAY_BUSY;
              end
            end
          endcase
        end
      end
      ST_STATUS_WR: begin
        // Commands other than reads are dropped while busy
        if (ctrl_reg.timer == '0) begin
          ctrl_next.write_enable = 1'b0;
          ctrl_next.state = ST_IDLE;
        end
      end
      ST_ARRAY_BUSY: begin
        if (ARRAY_DONE) begin
          ctrl_next.write_enable = 1'b0;
          ctrl_next.state = ST_IDLE;
        end
      end
      ST_SLEEP_ENTRY: begin
        if (ctrl_reg.timer == '0) begin
          ctrl_next.state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (frame_end && cmd_seen && op == RELEASE_ID_CMD) begin
          ctrl_next.timer = WR_LOAD;
          ctrl_next.state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (ctrl_reg.timer == '0) begin
          ctrl_next.state = ST_IDLE;
        end
      end
      default: ctrl_next.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg <= '0;
      ctrl_reg.state <= ST_IDLE;
      ctrl_reg.protect_level <= RST_PROTECT_LEVEL;
      ctrl_reg.protect_from_bottom <= RST_PROTECT_FROM_BOTTOM;
      ctrl_reg.status_lock <= RST_STATUS_LOCK;
      ctrl_reg.ce_sync <= 3'h7;
      ctrl_reg.wp_sync <= 2'h3;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[SR_BUSY] = BUSY;
    status_byte[SR_WRITE_ENABLE] = ctrl_reg.write_enable;
    status_byte[SR_PROTECT_LEVEL_BIT0 +: 3] = ctrl_reg.protect_level;
    status_byte[SR_PROTECT_FROM_BOTTOM] = ctrl_reg.protect_from_bottom;
    status_byte[SR_STATUS_LOCK] = ctrl_reg.status_lock;
  end

  assign BUSY = in_status_wr || ctrl_reg.state == ST_ARRAY_BUSY;
  assign ASLEEP = ctrl_reg.state == ST_SLEEP;
  assign WRITE_ENABLED = ctrl_reg.write_enable;
  assign PROTECT_LEVEL = ctrl_reg.protect_level;
  assign PROTECT_FROM_BOTTOM = ctrl_reg.protect_from_bottom;
  assign STATUS_LOCK = ctrl_reg.status_lock;
  assign ARRAY_REQ = ctrl_reg.array_req;
  assign ARRAY_OP = ctrl_reg.array_op;
  assign ARRAY_BYTES = ctrl_reg.array_bytes;
  assign PWR_READY = ctrl_reg.pwr_ready;

  localparam int A_SW_M1 = STATUS_WRITE_CYCLES - 1;
  localparam int A_SE_M1 = SLEEP_ENTRY_CYCLES - 1;
  localparam int A_WR_M1 = WAKE_RECOVERY_CYCLES - 1;

  default clocking a_clk @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  a_enable_sets_latch: assert property (
    ctrl_reg.state == ST_IDLE && frame_end && cmd_seen && aligned &&
    op == WRITE_ENABLE_CMD |=> WRITE_ENABLED
  ) else $error("write enable did not set the latch");

  a_disable_clr_latch: assert property (
    ctrl_reg.state == ST_IDLE && frame_end && cmd_seen && aligned &&
    op == WRITE_DISABLE_CMD |=> !WRITE_ENABLED
  ) else $error("write disable did not clear the latch");

  a_write_needs_latch: assert property (
    $rose(BUSY) |-> $past(ctrl_reg.write_enable)
  ) else $error("write started without the latch");

  a_status_wr_clear: assert property (
    $rose(in_status_wr) |-> !WRITE_ENABLED
  ) else $error("status write left the latch set");

  a_status_wr_time: assert property (
    $rose(in_status_wr) |-> ##A_SW_M1 in_status_wr ##1 !in_status_wr
  ) else $error("status write time wrong");

  a_locked_ignored: assert property (
    ctrl_reg.state == ST_IDLE && frame_end && op == STATUS_WRITE_CMD &&
    locked |=> $stable(PROTECT_LEVEL) && $stable(PROTECT_FROM_BOTTOM) &&
    ctrl_reg.state == ST_IDLE
  ) else $error("locked status write was taken");

  a_lock_sticky: assert property (
    !wp_s && STATUS_LOCK |=> STATUS_LOCK
  ) else $error("lock bit cleared with the pin low");

  a_sleep_busy_skip: assert property (
    frame_end && BUSY |=> ctrl_reg.state != ST_SLEEP_ENTRY
  ) else $error("sleep entered while busy");

  a_sleep_entry_time: assert property (
    $rose(ctrl_reg.state == ST_SLEEP_ENTRY) |->
      ##A_SE_M1 ctrl_reg.state == ST_SLEEP_ENTRY ##1 ASLEEP
  ) else $error("sleep entry time wrong");

  a_sleep_ignores: assert property (
    ASLEEP && frame_end && op != RELEASE_ID_CMD |=>
      ASLEEP && $stable(WRITE_ENABLED)
  ) else $error("command acted on while asleep");

  a_wake_time: assert property (
    $rose(ctrl_reg.state == ST_WAKE) |->
      ##A_WR_M1 ctrl_reg.state == ST_WAKE ##1 ctrl_reg.state == ST_IDLE
  ) else $error("wake recovery time wrong");

  a_misalign_reject: assert property (
    ctrl_reg.state == ST_IDLE && frame_end && !aligned &&
    op != PAGE_PROGRAM_CMD |=> $stable(WRITE_ENABLED) && !ARRAY_REQ
  ) else $error("misaligned write command taken");

  a_done_clears: assert property (
    ctrl_reg.state == ST_ARRAY_BUSY && ARRAY_DONE |=>
      !WRITE_ENABLED && !BUSY
  ) else $error("latch not cleared after write");
endmodule : fwpc_ctrl

// file: fwpc_host.sv
/*
  Host SPI controller model: mode 0, 125 ns serial clock.
  Assumes the bench resolves the data-out wire and passes it in.
*/
`timescale 1ns/100ps
module fwpc_host (
  output logic sck,
  output logic ce_n,
  output logic si,
  input wire logic so_line
);
  initial begin
    sck = 1'b0;
    ce_n = 1'b1;
    si = 1'b0;
  end
  // Clock runs only inside a frame, low between frames
  task automatic xfer(input logic [71:0] tx, input int n,
                      output logic [71:0] rx);
    rx = '0;
    #31 ce_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si = tx[i];
      #62.5 sck = 1'b1;
      rx = {rx[70:0], so_line};
      #62.5 sck = 1'b0;
    end
    #31 ce_n = 1'b1;
    si = ~si; // A released line must not look held
    #150;
  endtask : xfer
endmodule : fwpc_host

// file: tb.sv
/*
  Self-checking bench of the flash command controller.
  Assumes fwpc_host drives the link and the bench plays the array.
*/
`timescale 1ns/100ps
module tb;
  import fwpc_pkg::*;
  localparam int PU = 20;
  // Arbitrary identity values
  localparam logic [7:0] IDD = 8'h96;
  localparam logic [31:0] IDL = 32'h1E2D4B78;
  localparam logic [7:0] OPS [6] = '{8'h02, 8'h20, 8'hD7, 8'hD8,
                                     8'h60, 8'hC7};
  localparam int NB [6] = '{51, 32, 32, 32, 8, 8};
  logic MCLK = 1'b0;
  logic RST_N, SCK, CE_N, SI, WP_N;
  logic ARRAY_DONE = 1'b0;
  logic SO, SO_OE, ARRAY_REQ, BUSY, WRITE_ENABLED, PROTECT_FROM_BOTTOM;
  logic STATUS_LOCK, ASLEEP, PWR_READY;
  logic [7:0] ARRAY_OP;
  logic [PROG_BYTES_W-1:0] ARRAY_BYTES;
  logic [2:0] PROTECT_LEVEL;
  logic [71:0] rx;
  logic [7:0] d;
  logic [31:0] got;
  logic [31:0] exp_q[$];
  logic so_last = 1'b0;
  wire so_line;
  integer seed;
  int checks = 0;
  int n_mismatch = 0;
  int req_cnt = 0;
  event seen;

  always #12.5 MCLK = ~MCLK;
  // Undriven wire shows the inverse of its last driven level
  always @(SO or SO_OE) if (SO_OE) so_last = SO;
  assign so_line = SO_OE ? SO : ~so_last;

  fwpc_host host (.sck(SCK), .ce_n(CE_N), .si(SI), .so_line(so_line));

  fwpc_ctrl #(.POWERUP_CYCLES(PU), .ID_DEVICE(IDD),
    .ID_LONG_B0(IDL[31:24]), .ID_LONG_B1(IDL[23:16]),
    .ID_LONG_B2(IDL[15:8]), .ID_LONG_B3(IDL[7:0])) dut (
    .MCLK(MCLK), .RST_N(RST_N), .SCK(SCK), .CE_N(CE_N), .SI(SI),
    .WP_N(WP_N), .ARRAY_DONE(ARRAY_DONE), .SO(SO), .SO_OE(SO_OE),
    .ARRAY_REQ(ARRAY_REQ), .ARRAY_OP(ARRAY_OP),
    .ARRAY_BYTES(ARRAY_BYTES), .BUSY(BUSY),
    .WRITE_ENABLED(WRITE_ENABLED), .PROTECT_LEVEL(PROTECT_LEVEL),
    .PROTECT_FROM_BOTTOM(PROTECT_FROM_BOTTOM),
    .STATUS_LOCK(STATUS_LOCK), .ASLEEP(ASLEEP), .PWR_READY(PWR_READY)
  );

  // Array datapath stand-in: slow, random completion
  always begin
    @(posedge MCLK iff ARRAY_REQ === 1'b1);
    repeat (12 + ($unsigned($random(seed)) % 20)) @(negedge MCLK);
    ARRAY_DONE = 1'b1;
    @(negedge MCLK);
    ARRAY_DONE = 1'b0;
  end
  always @(posedge MCLK) if (ARRAY_REQ === 1'b1) req_cnt <= req_cnt + 1;

  always @(seen) begin
    logic [31:0] e;
    e = exp_q.pop_front();
    checks++;
    if (e !== got) begin
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, got);
      n_mismatch++;
    end
  end

  function automatic logic [7:0] stat();
    return {STATUS_LOCK, 1'b0, PROTECT_FROM_BOTTOM, PROTECT_LEVEL,
            WRITE_ENABLED, BUSY};
  endfunction : stat

  function automatic logic [7:0] exw(input logic [7:0] v);
    return {v[7], 1'b0, v[5], v[4:2], 2'b01};
  endfunction : exw

  task automatic note(input logic [31:0] e, input logic [31:0] g);
    exp_q.push_back(e);
    got = g;
    -> seen;
    #1;
  endtask : note

  task automatic cmd(input logic [71:0] tx, input int n);
    host.xfer(tx, n, rx);
    repeat (4) @(negedge MCLK);
  endtask : cmd

  task automatic idle();
    for (int k = 0; k < 400 && BUSY !== 1'b0; k++) @(negedge MCLK);
    note(0, BUSY);
  endtask : idle

  task automatic sw(input logic [7:0] v, input int n,
                    input logic [7:0] e);
    cmd(8'h06, 8);
    cmd({8'h01, v, 16'h0} >> (32 - n), n);
    note(e, stat());
    if (e[0]) begin
      repeat (60) @(negedge MCLK);
      note(1, BUSY);
      idle();
      note({e[7:2], 2'b00}, stat());
    end
  endtask : sw

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  initial begin
    #(60000 * 25);
    n_mismatch++;
    results();
  end

  initial begin
    seed = 32'h7DA87099;
    RST_N = 1'b0;
    WP_N = 1'b1;
    repeat (2) @(negedge MCLK);
    RST_N = 1'b1;
    note(8'h00, stat());
    note(0, PWR_READY);
    repeat (PU + 4) @(negedge MCLK);
    note(1, PWR_READY);
    cmd(8'h06, 8);
    note(8'h02, stat());
    cmd(9'h009, 9);
    note(8'h02, stat());
    cmd(8'h04, 8);
    note(8'h00, stat());
    cmd(16'h01FC, 16);
    note(8'h00, stat());
    d = $random(seed);
    sw(d, 16, exw(d));
    sw(8'h84, 24, exw(8'h84));
    sw(8'h00, 32, 8'h86);
    cmd(8'h04, 8);
    WP_N = 1'b0;
    sw(8'h00, 16, 8'h86);
    cmd(8'h04, 8);
    WP_N = 1'b1;
    sw(8'h00, 16, exw(8'h00));
    WP_N = 1'b0;
    sw(8'hB8, 16, exw(8'hB8));
    host.xfer({8'h05, 16'h0}, 24, rx);
    note({2{8'hB8}}, rx[15:0]);
    @(negedge MCLK);
    WP_N = 1'b1;
    sw(8'h00, 16, exw(8'h00));
    host.xfer({8'h9F, 40'h0}, 48, rx);
    note(IDL, rx[39:8]);
    note(IDL[31:24], rx[7:0]);
    cmd(8'h06, 8);
    cmd(16'h0100, 16);
    cmd(8'hB9, 8);
    repeat (130) @(negedge MCLK);
    note(0, ASLEEP);
    cmd(8'hB9, 8);
    note(0, ASLEEP);
    repeat (120) @(negedge MCLK);
    note(1, ASLEEP);
    cmd(8'h06, 8);
    note(8'h00, stat());
    host.xfer({8'hAB, 40'h0}, 48, rx);
    note({2{IDD}}, rx[15:0]);
    repeat (4) @(negedge MCLK);
    note(0, ASLEEP);
    repeat (130) @(negedge MCLK);
    cmd(8'h06, 8);
    note(8'h02, stat());
    cmd(8'h04, 8);
    cmd(40'h02000000AA, 40);
    note(0, req_cnt);
    for (int i = 0; i < 6; i++) begin
      cmd(8'h06, 8);
      cmd({OPS[i], 24'h0, 19'h2AAAA} >> (51 - NB[i]), NB[i]);
      note(1, BUSY);
      idle();
      note(OPS[i], ARRAY_OP);
      note(i == 0 ? 2 : 0, ARRAY_BYTES);
      note(8'h00, stat());
    end
    note(6, req_cnt);
    results();
  end
endmodule : tb
